// ===== bench/hcs_link_sva.sv
// Checker for the two-wire link between controller and slave.
// Assumes both ends run on i_clk and DIV is at least 4.
`timescale 1ns/1ps
module hcs_link_chk
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Link signals
	input wire logic scl_oe_m,
	input wire logic sda_oe_m,
	input wire logic sda_oe_s,
	input wire logic scl,
	input wire logic sda
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	// ----------------------------------------------------------------
	// Framing
	// ----------------------------------------------------------------
	sequence s_start;
		scl && $rose(sda_oe_m);
	endsequence
	sequence s_stop;
		scl && $fell(sda_oe_m);
	endsequence
	// Reset itself is the antecedent here, so it cannot be the disable.
	a_reset_quiet: assert property (disable iff (1'b0)
		!i_rst_n |=> !scl_oe_m && !sda_oe_m && !sda_oe_s)
		else $error("link driven right after reset");
	a_start_hold: assert property (s_start |=> scl [*3])
		else $error("clock fell too soon after start");
	a_start_clock: assert property (
		s_start |-> ##[1:600] $rose(scl_oe_m))
		else $error("no clock after start");
	a_stop_free: assert property (
		s_stop |-> !sda_oe_s ##1 (!scl_oe_m && !sda_oe_m) [*3])
		else $error("bus not free after stop");
	a_low_hold: assert property ($rose(scl_oe_m) |=> scl_oe_m [*4])
		else $error("clock low phase too short");
	a_high_hold: assert property ($fell(scl_oe_m) |=> !scl_oe_m [*4])
		else $error("clock high phase too short");
	a_clock_runs: assert property (
		$rose(scl_oe_m) |-> ##[1:600] $fell(scl_oe_m))
		else $error("clock stuck low");
	// The slave may only move data while the clock is low.
	a_slave_edge: assert property (
		$changed(sda_oe_s) |-> !scl || $past(!scl))
		else $error("slave moved data while clock high");
endmodule

// ===== bench/tb_hub_config_serial_slave.sv
// Testbench joining controller and configuration slave over the link.
// Assumes hcs_pkg and the link interface are compiled first.
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
	error_cnt++; $display("CHECK FAILED %s exp %0h got %0h", n, e, g); \
	end end
module tb_hub_config_serial_slave;
	import hcs_pkg::*;
	logic i_clk, i_rst_n, ref_ok, loaded, cyc, stb, we, ack, irq;
	logic int_n, attach, lock;
	logic [3:0] adr;
	logic [31:0] wdat, rdat, r;
	logic [7:0] ev, q;
	logic nk;
	int error_cnt, check_count;
	// ----------------------------------------------------------------
	// Both ends and the checker
	// ----------------------------------------------------------------
	hcs_link_if hcs_link_if_inst();
	hcs_cfg_slave #(.NUM_EVENTS(8)) hcs_cfg_slave_inst(.i_clk(i_clk),
		.i_rst_n(i_rst_n), .i_ref_clk_ok(ref_ok),
		.link(hcs_link_if_inst.slave), .i_events(ev),
		.i_defaults_loaded(loaded), .o_int_n(int_n), .o_attach(attach),
		.o_cfg_lock(lock));
	hcs_master_ctl hcs_master_ctl_inst(.i_clk(i_clk), .i_rst_n(i_rst_n),
		.i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
		.i_wb_sel(4'hF), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
		.link(hcs_link_if_inst.master), .o_irq(irq));
	hcs_link_chk hcs_link_chk_inst(.i_clk(i_clk), .i_rst_n(i_rst_n),
		.scl_oe_m(hcs_link_if_inst.scl_oe_m),
		.sda_oe_m(hcs_link_if_inst.sda_oe_m),
		.sda_oe_s(hcs_link_if_inst.sda_oe_s),
		.scl(hcs_link_if_inst.scl), .sda(hcs_link_if_inst.sda));
	initial
	begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end
	// ----------------------------------------------------------------
	// Bus tasks
	// ----------------------------------------------------------------
	task automatic wb(input logic w, input logic [3:0] a,
		input logic [31:0] d, output logic [31:0] o);
		int n;
		n = 0;
		@(posedge i_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do
		begin
			@(posedge i_clk);
			n++;
		end
		while (ack !== 1'b1 && n < 50);
		o = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (n >= 50)
			`CHK("wb_ack", 1'b1, ack)
	endtask
	task automatic link_op(input logic rd, input logic [7:0] p, d,
		output logic [7:0] o, output logic k);
		int n;
		n = 0;
		wb(1'b1, HCS_WB_ADDR, {24'h0, p}, r);
		wb(1'b1, HCS_WB_DATA, {24'h0, d}, r);
		wb(1'b1, HCS_WB_CTRL, {30'h0, rd, 1'b1}, r);
		do
		begin
			wb(1'b0, HCS_WB_STAT, 32'h0, r);
			n++;
		end
		while (r[0] !== 1'b0 && n < 500);
		if (n >= 500)
			`CHK("link_busy", 1'b0, r[0])
		k = r[1];
		wb(1'b0, HCS_WB_DATA, 32'h0, r);
		o = r[7:0];
	endtask
	task automatic lw(input logic [7:0] p, d);
		link_op(1'b0, p, d, q, nk);
		`CHK("write_nack", 1'b0, nk)
	endtask
	task automatic lchk(input logic [7:0] p, e);
		link_op(1'b1, p, 8'h00, q, nk);
		`CHK("read_nack", 1'b0, nk)
		`CHK("read_byte", e, q)
	endtask
	task automatic hard_reset();
		@(posedge i_clk);
		i_rst_n <= 1'b0;
		repeat (4) @(posedge i_clk);
		i_rst_n <= 1'b1;
		// Shorten the bit time; the default would make each byte long.
		wb(1'b1, HCS_WB_DIV, 32'h4, r);
	endtask
	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	task automatic t_reset();
		wb(1'b0, HCS_WB_DIV, 32'h0, r);
		`CHK("div", 32'h4, r)
		wb(1'b1, 4'h7, 32'hFF, r);
		wb(1'b0, 4'h7, 32'h0, r);
		`CHK("unmapped", 32'h0, r)
		lchk(HCS_INT_MASK, HCS_MASK_RESET_VAL);
		lchk(HCS_INT_STATUS, HCS_REG_RESET_VAL);
		lchk(HCS_STATUS_COMMAND, HCS_REG_RESET_VAL);
		`CHK("int_n", 1'b1, int_n)
		$display("test reset done");
	endtask
	task automatic t_reference_clock_input();
		@(posedge i_clk);
		ref_ok <= 1'b0;
		link_op(1'b0, 8'h10, 8'h11, q, nk);
		`CHK("nack_noref", 1'b1, nk)
		ref_ok <= 1'b1;
		lchk(8'h10, HCS_REG_RESET_VAL);
		$display("test reference_clock_input done");
	endtask
	task automatic t_data();
		wb(1'b1, HCS_WB_IMSK, 32'h1, r);
		lw(8'h10, 8'hA5);
		lw(HCS_PROT_LO_END, 8'h3C);
		lchk(8'h10, 8'hA5);
		lchk(HCS_PROT_LO_END, 8'h3C);
		`CHK("ctl_irq", 1'b1, irq)
		wb(1'b1, HCS_WB_IST, 32'h3, r);
		@(posedge i_clk);
		`CHK("ctl_irq_clr", 1'b0, irq)
		$display("test data done");
	endtask
	task automatic t_int();
		lw(HCS_INT_MASK, 8'hFE);
		@(posedge i_clk);
		ev <= 8'h03;
		@(posedge i_clk);
		ev <= 8'h00;
		repeat (3) @(posedge i_clk);
		`CHK("int_n_set", 1'b0, int_n)
		lchk(HCS_INT_STATUS, 8'h03);
		lw(HCS_INT_STATUS, 8'h01);
		repeat (2) @(posedge i_clk);
		`CHK("int_n_clr", 1'b1, int_n)
		lchk(HCS_INT_STATUS, 8'h02);
		$display("test interrupt done");
	endtask
	task automatic t_attach();
		lw(HCS_ATTACH_REG, 8'h01);
		repeat (2) @(posedge i_clk);
		`CHK("attach_early", 1'b0, attach)
		loaded <= 1'b1;
		repeat (3) @(posedge i_clk);
		`CHK("attach", 1'b1, attach)
		$display("test attach done");
	endtask
	task automatic t_soft();
		link_op(1'b0, HCS_STATUS_COMMAND, 8'h02, q, nk);
		lchk(8'h10, HCS_REG_RESET_VAL);
		lchk(HCS_INT_MASK, HCS_MASK_RESET_VAL);
		lchk(HCS_STATUS_COMMAND, HCS_REG_RESET_VAL);
		$display("test soft reset done");
	endtask
	task automatic t_lock();
		lw(HCS_STATUS_COMMAND, 8'h01);
		`CHK("lock_set", 1'b1, lock)
		lw(8'h10, 8'h77);
		lw(HCS_PROT_HI_BEG, 8'h12);
		lchk(8'h10, HCS_REG_RESET_VAL);
		lchk(HCS_PROT_HI_BEG, HCS_REG_RESET_VAL);
		lw(HCS_STATUS_COMMAND, 8'h00);
		`CHK("lock_kept", 1'b1, lock)
		hard_reset();
		`CHK("lock_pin", 1'b0, lock)
		lw(8'h10, 8'h66);
		lchk(8'h10, 8'h66);
		$display("test lock done");
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// ----------------------------------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------------------------------
	initial
	begin
		repeat (60000) @(posedge i_clk);
		error_cnt++;
		give_verdict();
	end
	initial
	begin
		i_rst_n = 1'b0;
		ref_ok = 1'b1;
		loaded = 1'b0;
		ev = 8'h00;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 4'h0;
		wdat = 32'h0;
		error_cnt = 0;
		check_count = 0;
		repeat (4) @(posedge i_clk);
		i_rst_n <= 1'b1;
		wb(1'b1, HCS_WB_DIV, 32'h4, r);
		t_reset();
		t_reference_clock_input();
		t_data();
		t_int();
		t_attach();
		t_soft();
		t_lock();
		give_verdict();
	end
endmodule

// ===== src/hcs_cfg_slave.sv
// Configuration serial slave of the hub: byte registers, lock, interrupt.
// Assumes the link lines are synchronous to i_clk, oversampled heavily.
`timescale 1ns/1ps
module hcs_cfg_slave
	import hcs_pkg::*;
#(
	parameter int NUM_EVENTS = 8
)
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_ref_clk_ok,
	// Link
	hcs_link_if.slave link,
	// Hub core side
	input wire logic [NUM_EVENTS-1:0] i_events,
	input wire logic i_defaults_loaded,
	output logic o_int_n,
	output logic o_attach,
	output logic o_cfg_lock
);
	import hcs_pkg::*;

	typedef enum {S_IDLE, S_ADDR, S_ADDR_ACK, S_PTR, S_PTR_ACK, S_WR,
		S_WR_ACK, S_RD, S_RD_ACK, S_SKIP} hcs_sst_e;

	// ------------------------------------------------------------
	// Line edge and condition detection
	// ------------------------------------------------------------
	logic scl_d_reg;
	logic sda_d_reg;
	logic scl_rise;
	logic scl_fall;
	logic start_cond;
	logic stop_cond;

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
		end
		else
		begin
			scl_d_reg <= link.scl;
			sda_d_reg <= link.sda;
		end
	end

	// Rates up to 1 Mbps leave many samples per bit at 100 MHz.
	assign scl_rise = link.scl & ~scl_d_reg;
	assign scl_fall = ~link.scl & scl_d_reg;
	assign start_cond = link.scl & scl_d_reg & sda_d_reg & ~link.sda;
	assign stop_cond = link.scl & scl_d_reg & ~sda_d_reg & link.sda;

	// ------------------------------------------------------------
	// Register storage
	// ------------------------------------------------------------
	logic [7:0] mem_reg [0:255];
	logic [7:0] int_status_reg;
	logic [7:0] int_mask_reg;
	logic lock_reg;
	logic soft_rst_reg;
	logic wr_en;
	logic [7:0] ptr_reg;
	logic [7:0] shift_reg;
	logic [2:0] bit_cnt_reg;
	hcs_sst_e st_reg;
	logic rw_reg;
	logic sda_oe_reg;
	logic got_bit_reg;

	function automatic logic is_protected(input logic [7:0] a);
		is_protected = (a <= HCS_PROT_LO_END) || (a >= HCS_PROT_HI_BEG);
	endfunction

	function automatic logic [7:0] read_reg(input logic [7:0] a);
		if (a == HCS_STATUS_COMMAND)
			read_reg = {6'h00, 1'b0, lock_reg};
		else if (a == HCS_INT_STATUS)
			read_reg = int_status_reg;
		else if (a == HCS_INT_MASK)
			read_reg = int_mask_reg;
		else
			read_reg = mem_reg[a];
	endfunction

	// A soft reset drops any transfer in progress as well.
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n || soft_rst_reg)
			soft_rst_reg <= 1'b0;
		else if (wr_en && ptr_reg == HCS_STATUS_COMMAND)
			soft_rst_reg <= shift_reg[HCS_SC_RESET_BIT];
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
			lock_reg <= 1'b0;
		else if (wr_en && ptr_reg == HCS_STATUS_COMMAND && !lock_reg)
			lock_reg <= shift_reg[HCS_SC_LOCK_BIT];
	end

	// Discarded writes keep the bus moving; the master sees an ACK.
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n || soft_rst_reg)
		begin
			for (int i = 0; i < 256; i++)
				mem_reg[i] <= HCS_REG_RESET_VAL;
		end
		else if (wr_en && !(lock_reg && is_protected(ptr_reg)))
			mem_reg[ptr_reg] <= shift_reg;
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n || soft_rst_reg)
			int_mask_reg <= HCS_MASK_RESET_VAL;
		else if (wr_en && ptr_reg == HCS_INT_MASK)
			int_mask_reg <= shift_reg;
	end

	// Set wins over clear; masked events are kept too.
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n || soft_rst_reg)
			int_status_reg <= 8'h00;
		else if (wr_en && ptr_reg == HCS_INT_STATUS)
			int_status_reg <= (int_status_reg & ~shift_reg) |
				8'(i_events);
		else
			int_status_reg <= int_status_reg | 8'(i_events);
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
			o_int_n <= 1'b1;
		else
			o_int_n <= ~|(int_status_reg & ~int_mask_reg);
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
			o_attach <= 1'b0;
		else
			o_attach <= i_defaults_loaded &
				mem_reg[HCS_ATTACH_REG][0];
	end

	assign o_cfg_lock = lock_reg;
	assign link.sda_oe_s = sda_oe_reg;

	// ------------------------------------------------------------
	// Protocol engine
	// ------------------------------------------------------------
	assign wr_en = (st_reg == S_WR) && scl_fall && (bit_cnt_reg == 3'd0) &&
		i_ref_clk_ok;

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n || soft_rst_reg || !i_ref_clk_ok)
		begin
			st_reg <= S_IDLE;
			sda_oe_reg <= 1'b0;
			bit_cnt_reg <= 3'd7;
			shift_reg <= 8'h00;
			rw_reg <= 1'b0;
			ptr_reg <= 8'h00;
			got_bit_reg <= 1'b0;
		end
		else if (start_cond)
		begin
			st_reg <= S_ADDR;
			bit_cnt_reg <= 3'd7;
			sda_oe_reg <= 1'b0;
			got_bit_reg <= 1'b0;
		end
		else if (stop_cond)
		begin
			st_reg <= S_IDLE;
			sda_oe_reg <= 1'b0;
		end
		else
		begin
			case (st_reg)
				S_ADDR, S_PTR, S_WR:
				begin
					// The clock fall that follows a start carries no bit.
					if (scl_rise)
					begin
						shift_reg <= {shift_reg[6:0], link.sda};
						got_bit_reg <= 1'b1;
					end
					if (scl_fall && got_bit_reg)
					begin
						if (bit_cnt_reg != 3'd0)
							bit_cnt_reg <= bit_cnt_reg - 3'd1;
						else if (st_reg == S_ADDR)
						begin
							rw_reg <= shift_reg[0];
							if (shift_reg[7:1] == HCS_SLAVE_ADDR)
							begin
								sda_oe_reg <= 1'b1;
								st_reg <= S_ADDR_ACK;
							end
							else
								st_reg <= S_SKIP;
						end
						else
						begin
							sda_oe_reg <= 1'b1;
							if (st_reg == S_PTR)
							begin
								ptr_reg <= shift_reg;
								st_reg <= S_PTR_ACK;
							end
							else
								st_reg <= S_WR_ACK;
						end
					end
				end
				S_ADDR_ACK, S_PTR_ACK, S_WR_ACK:
				begin
					if (scl_fall)
					begin
						bit_cnt_reg <= 3'd7;
						if (st_reg == S_ADDR_ACK && rw_reg)
						begin
							shift_reg <= read_reg(ptr_reg);
							sda_oe_reg <= ~|(read_reg(ptr_reg) & 8'h80);
							ptr_reg <= ptr_reg + 8'd1;
							st_reg <= S_RD;
						end
						else
						begin
							sda_oe_reg <= 1'b0;
							if (st_reg == S_WR_ACK)
								ptr_reg <= ptr_reg + 8'd1;
							st_reg <= (st_reg == S_ADDR_ACK) ? S_PTR :
								S_WR;
						end
					end
				end
				S_RD:
				begin
					if (scl_fall)
					begin
						if (bit_cnt_reg != 3'd0)
						begin
							bit_cnt_reg <= bit_cnt_reg - 3'd1;
							shift_reg <= {shift_reg[6:0], 1'b0};
							sda_oe_reg <= ~shift_reg[6];
						end
						else
						begin
							sda_oe_reg <= 1'b0;
							st_reg <= S_RD_ACK;
						end
					end
				end
				S_RD_ACK:
				begin
					// A not-acknowledge from the master ends the read.
					if (scl_rise && link.sda)
						st_reg <= S_SKIP;
					else if (scl_fall)
					begin
						bit_cnt_reg <= 3'd7;
						shift_reg <= read_reg(ptr_reg);
						sda_oe_reg <= ~|(read_reg(ptr_reg) & 8'h80);
						ptr_reg <= ptr_reg + 8'd1;
						st_reg <= S_RD;
					end
				end
				S_IDLE, S_SKIP:
					sda_oe_reg <= 1'b0;
				default:
					st_reg <= S_IDLE;
			endcase
		end
	end
endmodule

// ===== src/hcs_link_if.sv
// Two-wire link joining the controller and the configuration slave.
// Assumes open-drain pull-up; each end drives low only when enabled.
`timescale 1ns/1ps
interface hcs_link_if;
	logic scl_oe_m;
	logic sda_oe_m;
	logic sda_oe_s;
	logic scl;
	logic sda;

	assign scl = ~scl_oe_m;
	assign sda = ~(sda_oe_m | sda_oe_s);

	modport master
	(
		output scl_oe_m,
		output sda_oe_m,
		input scl,
		input sda
	);
	modport slave
	(
		output sda_oe_s,
		input scl,
		input sda
	);
endinterface

// ===== src/hcs_master_ctl.sv
// Controller end: Wishbone slave ordering single-byte link transfers.
// Assumes the slave end is joined through hcs_link_if on the same clock.
`timescale 1ns/1ps
module hcs_master_ctl
	import hcs_pkg::*;
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Wishbone slave
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [3:0] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	// Link
	hcs_link_if.master link,
	// Interrupt
	output logic o_irq
);
	import hcs_pkg::*;

	typedef enum {M_IDLE, M_START, M_BIT, M_ACK, M_RSTART, M_STOP}
		hcs_mst_e;

	// ------------------------------------------------------------
	// Software registers
	// ------------------------------------------------------------
	logic [7:0] addr_reg;
	logic [7:0] wdata_reg;
	logic [7:0] rdata_reg;
	logic go_reg;
	logic rd_reg;
	logic busy_reg;
	logic nack_reg;
	logic [1:0] ist_reg;
	logic [1:0] imsk_reg;
	logic [15:0] div_reg;
	logic wb_wr;
	logic done_pulse;
	logic nack_pulse;

	assign wb_wr = i_wb_cyc & i_wb_stb & i_wb_we & ~o_wb_ack & i_wb_sel[0];

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
			o_wb_ack <= 1'b0;
		else
			o_wb_ack <= i_wb_cyc & i_wb_stb & ~o_wb_ack;
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
			o_wb_dat <= 32'h0000_0000;
		else
			case (i_wb_adr)
				HCS_WB_ADDR: o_wb_dat <= {24'h0, addr_reg};
				HCS_WB_DATA: o_wb_dat <= {24'h0, rdata_reg};
				HCS_WB_STAT: o_wb_dat <= {30'h0, nack_reg, busy_reg};
				HCS_WB_IST: o_wb_dat <= {30'h0, ist_reg};
				HCS_WB_IMSK: o_wb_dat <= {30'h0, imsk_reg};
				HCS_WB_DIV: o_wb_dat <= {16'h0, div_reg};
				default: o_wb_dat <= 32'h0000_0000;
			endcase
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			addr_reg <= 8'h00;
			wdata_reg <= 8'h00;
			imsk_reg <= 2'b00;
			div_reg <= 16'(HCS_QDIV);
		end
		else if (wb_wr)
			case (i_wb_adr)
				HCS_WB_ADDR: addr_reg <= i_wb_dat[7:0];
				HCS_WB_DATA: wdata_reg <= i_wb_dat[7:0];
				HCS_WB_IMSK: imsk_reg <= i_wb_dat[1:0];
				HCS_WB_DIV: div_reg <= i_wb_dat[15:0];
				default: ;
			endcase
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			go_reg <= 1'b0;
			rd_reg <= 1'b0;
		end
		else
		begin
			go_reg <= wb_wr && i_wb_adr == HCS_WB_CTRL && !busy_reg &&
				i_wb_dat[0];
			if (wb_wr && i_wb_adr == HCS_WB_CTRL && !busy_reg)
				rd_reg <= i_wb_dat[1];
		end
	end

	// Events set over the write-one clear.
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
			ist_reg <= 2'b00;
		else if (wb_wr && i_wb_adr == HCS_WB_IST)
			ist_reg <= (ist_reg & ~i_wb_dat[1:0]) |
				{nack_pulse, done_pulse};
		else
			ist_reg <= ist_reg | {nack_pulse, done_pulse};
	end

	assign o_irq = |(ist_reg & imsk_reg);

	// ------------------------------------------------------------
	// Bit engine: quarter-period enable and transfer sequencer
	// ------------------------------------------------------------
	logic [15:0] qcnt_reg;
	logic tick;
	hcs_mst_e st_reg;
	logic [1:0] ph_reg;
	logic [2:0] bit_reg;
	logic [1:0] byte_reg;
	logic [7:0] sh_reg;
	logic scl_lo_reg;
	logic sda_lo_reg;

	assign tick = (qcnt_reg == 16'h0000);
	assign link.scl_oe_m = scl_lo_reg;
	assign link.sda_oe_m = sda_lo_reg;
	assign done_pulse = tick && st_reg == M_STOP && ph_reg == 2'd3;
	assign nack_pulse = tick && st_reg == M_ACK && ph_reg == 2'd2 &&
		link.sda && !(rd_reg && byte_reg == 2'd3);

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n || tick)
			qcnt_reg <= div_reg;
		else
			qcnt_reg <= qcnt_reg - 16'h0001;
	end

	// Byte order: address+W, pointer, then data (write) or
	// repeated start, address+R, data with not-acknowledge (read).
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			st_reg <= M_IDLE;
			ph_reg <= 2'd0;
			bit_reg <= 3'd7;
			byte_reg <= 2'd0;
			sh_reg <= 8'h00;
			scl_lo_reg <= 1'b0;
			sda_lo_reg <= 1'b0;
			busy_reg <= 1'b0;
			nack_reg <= 1'b0;
			rdata_reg <= 8'h00;
		end
		else if (go_reg)
		begin
			busy_reg <= 1'b1;
			nack_reg <= 1'b0;
			st_reg <= M_START;
			ph_reg <= 2'd0;
			byte_reg <= 2'd0;
			sh_reg <= {HCS_SLAVE_ADDR, 1'b0};
		end
		else if (tick)
		begin
			ph_reg <= ph_reg + 2'd1;
			case (st_reg)
				M_START, M_RSTART:
				begin
					if (ph_reg == 2'd0)
					begin
						sda_lo_reg <= 1'b0;
						scl_lo_reg <= 1'b0;
					end
					else if (ph_reg == 2'd1)
						sda_lo_reg <= 1'b1;
					else if (ph_reg == 2'd2)
						scl_lo_reg <= 1'b1;
					else
					begin
						bit_reg <= 3'd7;
						st_reg <= M_BIT;
					end
				end
				M_BIT:
				begin
					if (ph_reg == 2'd0)
						sda_lo_reg <= (rd_reg && byte_reg == 2'd3) ? 1'b0 :
							~sh_reg[7];
					else if (ph_reg == 2'd1)
						scl_lo_reg <= 1'b0;
					else if (ph_reg == 2'd2)
						sh_reg <= {sh_reg[6:0], link.sda};
					else
					begin
						scl_lo_reg <= 1'b1;
						bit_reg <= bit_reg - 3'd1;
						if (bit_reg == 3'd0)
							st_reg <= M_ACK;
					end
				end
				M_ACK:
				begin
					if (ph_reg == 2'd0)
						sda_lo_reg <= rd_reg && byte_reg == 2'd3 ? 1'b0 :
							1'b0;
					else if (ph_reg == 2'd1)
						scl_lo_reg <= 1'b0;
					else if (ph_reg == 2'd2)
					begin
						if (nack_pulse)
							nack_reg <= 1'b1;
					end
					else
					begin
						scl_lo_reg <= 1'b1;
						sda_lo_reg <= 1'b1;
						byte_reg <= byte_reg + 2'd1;
						bit_reg <= 3'd7;
						if (nack_reg || (byte_reg == 2'd2 && !rd_reg) ||
							byte_reg == 2'd3)
						begin
							if (byte_reg == 2'd3)
								rdata_reg <= sh_reg;
							st_reg <= M_STOP;
						end
						else if (byte_reg == 2'd1 && rd_reg)
						begin
							sda_lo_reg <= 1'b0;
							sh_reg <= {HCS_SLAVE_ADDR, 1'b1};
							st_reg <= M_RSTART;
						end
						else
						begin
							sh_reg <= (byte_reg == 2'd0) ? addr_reg :
								wdata_reg;
							st_reg <= M_BIT;
						end
					end
				end
				M_STOP:
				begin
					if (ph_reg == 2'd1)
						scl_lo_reg <= 1'b0;
					else if (ph_reg == 2'd2)
						sda_lo_reg <= 1'b0;
					else if (ph_reg == 2'd3)
					begin
						busy_reg <= 1'b0;
						st_reg <= M_IDLE;
					end
				end
				M_IDLE:
				begin
					scl_lo_reg <= 1'b0;
					sda_lo_reg <= 1'b0;
				end
				default:
					st_reg <= M_IDLE;
			endcase
		end
	end
endmodule

// ===== src/hcs_pkg.sv
// Shared constants for the hub configuration serial link.
// Assumes a 100 MHz system clock on both ends of the link.
package hcs_pkg;
	// ----------------------------------------------------------------
	// Link addressing and register map
	// ----------------------------------------------------------------
	localparam logic [6:0] HCS_SLAVE_ADDR = 7'h08;
	localparam logic [7:0] HCS_STATUS_COMMAND = 8'hFF;
	localparam logic [7:0] HCS_INT_STATUS = 8'hE8;
	localparam logic [7:0] HCS_INT_MASK = 8'hE9;
	localparam logic [7:0] HCS_PROT_LO_END = 8'hE1;
	localparam logic [7:0] HCS_PROT_HI_BEG = 8'hEF;
	localparam logic [7:0] HCS_ATTACH_REG = 8'hE7;
	localparam int HCS_SC_RESET_BIT = 1;
	localparam int HCS_SC_LOCK_BIT = 0;
	localparam logic [7:0] HCS_REG_RESET_VAL = 8'h00;
	localparam logic [7:0] HCS_MASK_RESET_VAL = 8'hFF;

	// ----------------------------------------------------------------
	// Controller register offsets on the Wishbone side (word index)
	// ----------------------------------------------------------------
	localparam logic [3:0] HCS_WB_CTRL = 4'h0;
	localparam logic [3:0] HCS_WB_ADDR = 4'h1;
	localparam logic [3:0] HCS_WB_DATA = 4'h2;
	localparam logic [3:0] HCS_WB_STAT = 4'h3;
	localparam logic [3:0] HCS_WB_IST = 4'h4;
	localparam logic [3:0] HCS_WB_IMSK = 4'h5;
	localparam logic [3:0] HCS_WB_DIV = 4'h6;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int HCS_CLK_MHZ = 100;
	localparam int HCS_SCL_KHZ = 100;
	// Quarter-period enable count for the bus clock.
	localparam int HCS_QDIV = (HCS_CLK_MHZ * 1000) / (HCS_SCL_KHZ * 4);
endpackage
